/* core/fifo_word_pkg.sv */
package fifo_word_pkg;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } axis_t;

  typedef struct packed {
    logic [7:0] tag;
    logic [7:0] x_low;
    logic [7:0] x_high;
    logic [7:0] y_low;
    logic [7:0] y_high;
    logic [7:0] z_low;
    logic [7:0] z_high;
  } word_t;

  // Pending words, lowest bit leaves first
  typedef struct packed {
    logic temp;
    logic ts;
    logic cfg;
    logic accel;
    logic gyro;
  } job_t;

  // ----------------------------------------------------------------------
  // Word source codes
  // ----------------------------------------------------------------------
  localparam logic [4:0] ID_GYRO  = 5'h01;
  localparam logic [4:0] ID_ACCEL = 5'h02;
  localparam logic [4:0] ID_TEMP  = 5'h03;
  localparam logic [4:0] ID_TS    = 5'h04;
  localparam logic [4:0] ID_CFG   = 5'h05;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [6:0] IDX_BATCH  = 7'h00;
  localparam logic [6:0] IDX_ODR    = 7'h01;
  localparam logic [6:0] IDX_AUX    = 7'h02;
  localparam logic [6:0] IDX_GFILT  = 7'h03;
  localparam logic [6:0] IDX_AFILT  = 7'h04;
  localparam logic [6:0] IDX_STATUS = 7'h05;
  localparam logic [6:0] IDX_TAG    = 7'h78;
  localparam logic [6:0] IDX_X_LOW  = 7'h79;
  localparam logic [6:0] IDX_X_HIGH = 7'h7a;
  localparam logic [6:0] IDX_Y_LOW  = 7'h7b;
  localparam logic [6:0] IDX_Y_HIGH = 7'h7c;
  localparam logic [6:0] IDX_Z_LOW  = 7'h7d;
  localparam logic [6:0] IDX_Z_HIGH = 7'h7e;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ACCEL_LSB   = 0;
  localparam int GYRO_LSB    = 4;
  localparam int TEMP_LSB    = 0;
  localparam int DEC_LSB     = 2;
  localparam int TS_EN_BIT   = 4;
  localparam int CFG_EN_BIT  = 5;
  localparam int HUB_ODR_LSB = 6;
  localparam int HUB_EN_BIT  = 8;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_PEND_BIT = 2;
  localparam int ST_HUB_LSB  = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_BATCH = 8'h00;
  localparam logic [7:0] RST_ODR   = 8'h00;
  localparam logic [8:0] RST_AUX   = 9'h000;
  localparam logic [7:0] RST_FILT  = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 10_000_000;
  localparam int GYRO_STARTUP_MS = 70;
  localparam int STARTUP_CYCLES  = GYRO_STARTUP_MS * (CLK_HZ / 1000);

endpackage

/* core/fifo_batch_word_formatter.sv */
// The placing of the registers and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Operation
// (RULE1) Separate four-bit batch rates per main sensor
// (RULE2) Host keeps batch rate within output rate
// (RULE3) Main-sensor batch events form the time base
// (RULE4) Faster sensor event advances two-bit slot counter
// (RULE5) Slot rate equals larger batch rate
// (RULE6) Main word: tag then X, Y, Z bytes
// (RULE7) Auxiliary words only follow a main event
// (RULE8) Temperature batched only when rate selected
// (RULE9) Timestamp needs enable and nonzero decimation
// (RULE10) Config-change words only when enabled
// (RULE11) Temperature word: value in X, rest zero
// (RULE12) Timestamp word layout with rate fields
// (RULE13) Hub rate derived, limited by trigger rate
// (RULE14) Config-change word, then forced timestamp word
// (RULE15) Config-change filter and scale byte layout
// (RULE16) Config-change rate byte layout
// (RULE17) Gyro start-up flag, released within 70 ms
// (RULE18) Five-bit source codes in tag
// (RULE19) Tag: id, slot, even parity
// (RULE20) Aux words follow main words, same slot
module fifo_batch_word_formatter #(
  parameter logic [19:0] STARTUP_CYCLES = 20'(fifo_word_pkg::STARTUP_CYCLES)
) (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [31:0]          wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic                      wb_ack_o,
  input  wire logic                 accel_evt_i,
  input  wire logic                 gyro_evt_i,
  input  wire fifo_word_pkg::axis_t accel_data_i,
  input  wire fifo_word_pkg::axis_t gyro_data_i,
  input  wire logic [15:0]          temp_data_i,
  input  wire logic [31:0]          timestamp_i,
  output logic                      word_valid_o,
  output fifo_word_pkg::word_t      word_o,
  input  wire logic                 word_ready_i,
  output logic [1:0]                slot_counter_o
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  function automatic logic [7:0] make_tag(input logic [4:0] id, input logic [1:0] slot);
    make_tag = {id, slot, ^{id, slot}}; // RULE19
  endfunction

  function automatic logic [3:0] max4(input logic [3:0] a, input logic [3:0] b);
    max4 = (a > b) ? a : b;
  endfunction

  function automatic logic dec_due(input logic [1:0] dec, input logic [1:0] cnt);
    case (dec)
      2'h1:    dec_due = 1'b1;
      2'h2:    dec_due = ~cnt[0];
      2'h3:    dec_due = (cnt == 2'h0);
      default: dec_due = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  logic [7:0]           batch_q;
  logic [7:0]           odr_q;
  logic [8:0]           aux_q;
  logic [7:0]           gfilt_q;
  logic [7:0]           afilt_q;
  logic                 ack_q;
  logic [31:0]          rdat_q;
  logic [6:0]           idx;
  logic                 wr;
  logic [7:0]           batch_d;
  logic [7:0]           odr_d;
  logic [8:0]           aux_d;
  logic [7:0]           gfilt_d;
  logic [7:0]           afilt_d;
  fifo_word_pkg::word_t last_q;
  logic                 cfg_pend_q;
  logic [1:0]           slot_q;
  fifo_word_pkg::job_t  job_q;
  logic [3:0]           hub_rate;

  assign idx = wb_adr_i[8:2];
  assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;

  always_comb begin
    batch_d = batch_q;
    odr_d   = odr_q;
    aux_d   = aux_q;
    gfilt_d = gfilt_q;
    afilt_d = afilt_q;
    if (wr) begin
      unique case (idx)
        fifo_word_pkg::IDX_BATCH: batch_d = lane(batch_q, wb_dat_i[7:0], wb_sel_i[0]);
        fifo_word_pkg::IDX_ODR:   odr_d   = lane(odr_q, wb_dat_i[7:0], wb_sel_i[0]);
        fifo_word_pkg::IDX_AUX: begin
          aux_d[7:0] = lane(aux_q[7:0], wb_dat_i[7:0], wb_sel_i[0]);
          aux_d[8]   = wb_sel_i[1] ? wb_dat_i[8] : aux_q[8];
        end
        fifo_word_pkg::IDX_GFILT: gfilt_d = lane(gfilt_q, wb_dat_i[7:0], wb_sel_i[0]);
        fifo_word_pkg::IDX_AFILT: afilt_d = {lane(afilt_q, wb_dat_i[7:0], wb_sel_i[0])} &
                                            8'hdf;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      batch_q <= fifo_word_pkg::RST_BATCH;
      odr_q   <= fifo_word_pkg::RST_ODR;
      aux_q   <= fifo_word_pkg::RST_AUX;
      gfilt_q <= fifo_word_pkg::RST_FILT;
      afilt_q <= fifo_word_pkg::RST_FILT;
    end else begin
      batch_q <= batch_d; // RULE1
      odr_q   <= odr_d;
      aux_q   <= aux_d;
      gfilt_q <= gfilt_d;
      afilt_q <= afilt_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= wb_cyc_i && wb_stb_i && !ack_q;
      rdat_q <= 32'h0000_0000;
      unique case (idx)
        fifo_word_pkg::IDX_BATCH:  rdat_q[7:0] <= batch_q;
        fifo_word_pkg::IDX_ODR:    rdat_q[7:0] <= odr_q;
        fifo_word_pkg::IDX_AUX:    rdat_q[8:0] <= aux_q;
        fifo_word_pkg::IDX_GFILT:  rdat_q[7:0] <= gfilt_q;
        fifo_word_pkg::IDX_AFILT:  rdat_q[7:0] <= afilt_q;
        fifo_word_pkg::IDX_STATUS: rdat_q[7:0] <= {hub_rate, |job_q, cfg_pend_q, slot_q};
        fifo_word_pkg::IDX_TAG:    rdat_q[7:0] <= last_q.tag;
        fifo_word_pkg::IDX_X_LOW:  rdat_q[7:0] <= last_q.x_low;
        fifo_word_pkg::IDX_X_HIGH: rdat_q[7:0] <= last_q.x_high;
        fifo_word_pkg::IDX_Y_LOW:  rdat_q[7:0] <= last_q.y_low;
        fifo_word_pkg::IDX_Y_HIGH: rdat_q[7:0] <= last_q.y_high;
        fifo_word_pkg::IDX_Z_LOW:  rdat_q[7:0] <= last_q.z_low;
        fifo_word_pkg::IDX_Z_HIGH: rdat_q[7:0] <= last_q.z_high;
        default: ;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------------
  // Rates, time base and slot counter
  // ----------------------------------------------------------------------
  logic [3:0] accel_rate;
  logic [3:0] gyro_rate;
  logic [3:0] accel_odr;
  logic [3:0] gyro_odr;
  logic       accel_hit;
  logic       gyro_hit;
  logic       main_hit;
  logic       slot_adv;
  logic [1:0] slot_d;
  logic [3:0] hub_code;

  assign accel_rate = batch_q[fifo_word_pkg::ACCEL_LSB +: 4];
  assign gyro_rate  = batch_q[fifo_word_pkg::GYRO_LSB +: 4];
  assign accel_odr  = odr_q[fifo_word_pkg::ACCEL_LSB +: 4];
  assign gyro_odr   = odr_q[fifo_word_pkg::GYRO_LSB +: 4];
  assign accel_hit  = accel_evt_i && (accel_rate != 4'h0); // RULE3
  assign gyro_hit   = gyro_evt_i && (gyro_rate != 4'h0); // RULE3
  assign main_hit   = accel_hit || gyro_hit;
  assign slot_adv   = (gyro_rate > accel_rate) ? gyro_hit : accel_hit; // RULE5
  assign slot_d     = slot_adv ? slot_q + 2'h1 : slot_q; // RULE4

  assign hub_code = {2'h0, aux_q[fifo_word_pkg::HUB_ODR_LSB +: 2]} + 4'h1;
  assign hub_rate = !aux_q[fifo_word_pkg::HUB_EN_BIT] ? 4'h0 :
                    (hub_code > max4(accel_odr, gyro_odr)) ? max4(accel_odr, gyro_odr) :
                    hub_code; // RULE13

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slot_q <= 2'h0;
    end else begin
      slot_q <= slot_d; // RULE4
    end
  end

  assign slot_counter_o = slot_q;

  // ----------------------------------------------------------------------
  // Auxiliary triggers
  // ----------------------------------------------------------------------
  logic       cfg_set;
  logic       cfg_take;
  logic       ts_due;
  logic       temp_due;
  logic [1:0] ts_cnt_q;
  logic [1:0] dec;

  assign dec      = aux_q[fifo_word_pkg::DEC_LSB +: 2];
  assign ts_due   = slot_adv && aux_q[fifo_word_pkg::TS_EN_BIT] && dec_due(dec, ts_cnt_q); // RULE9
  assign temp_due = slot_adv && (aux_q[fifo_word_pkg::TEMP_LSB +: 2] != 2'h0); // RULE8
  assign cfg_take = main_hit && cfg_pend_q; // RULE7
  assign cfg_set  = aux_q[fifo_word_pkg::CFG_EN_BIT] &&
                    (batch_d != batch_q || odr_d != odr_q || gfilt_d != gfilt_q ||
                     afilt_d != afilt_q || aux_d[8:6] != aux_q[8:6]); // RULE10

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_pend_q <= 1'b0;
      ts_cnt_q   <= 2'h0;
    end else begin
      cfg_pend_q <= (cfg_pend_q && !cfg_take) || cfg_set; // RULE14
      if (slot_adv) begin
        ts_cnt_q <= ts_cnt_q + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Gyro start-up timer
  // ----------------------------------------------------------------------
  logic [19:0] startup_q;
  logic        gyro_on_q;
  logic        gyro_on;

  assign gyro_on = (gyro_odr != 4'h0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      startup_q <= 20'h00000;
      gyro_on_q <= 1'b0;
    end else begin
      gyro_on_q <= gyro_on;
      if (gyro_on && !gyro_on_q) begin
        startup_q <= STARTUP_CYCLES; // RULE17
      end else if (!gyro_on) begin
        startup_q <= 20'h00000;
      end else if (startup_q != 20'h00000) begin
        startup_q <= startup_q - 20'h00001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Snapshots and pending words
  // ----------------------------------------------------------------------
  fifo_word_pkg::axis_t accel_snap_q;
  fifo_word_pkg::axis_t gyro_snap_q;
  logic [15:0]          temp_snap_q;
  logic [31:0]          ts_snap_q;
  logic [1:0]           slot_snap_q;
  fifo_word_pkg::job_t  new_job;
  fifo_word_pkg::job_t  pick;
  logic                 out_valid_q;
  fifo_word_pkg::word_t out_q;
  logic                 load;

  assign new_job = '{temp: temp_due, ts: ts_due || cfg_take, cfg: cfg_take,
                     accel: accel_hit, gyro: gyro_hit}; // RULE14
  assign load    = !out_valid_q || word_ready_i;
  assign pick    = job_q & (~job_q + 5'h01); // RULE20

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accel_snap_q <= '0;
      gyro_snap_q  <= '0;
      temp_snap_q  <= 16'h0000;
      ts_snap_q    <= 32'h0000_0000;
      slot_snap_q  <= 2'h0;
    end else begin
      if (accel_hit) begin
        accel_snap_q <= accel_data_i;
      end
      if (gyro_hit) begin
        gyro_snap_q <= gyro_data_i;
      end
      if (main_hit) begin
        temp_snap_q <= temp_data_i;
        ts_snap_q   <= timestamp_i;
        slot_snap_q <= slot_d; // RULE20
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      job_q <= '0;
    end else begin
      job_q <= (job_q & ~(load ? pick : 5'h00)) | new_job;
    end
  end

  // ----------------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------------
  fifo_word_pkg::word_t nxt;

  always_comb begin
    nxt = '0;
    unique case (1'b1)
      pick.gyro: begin
        nxt.tag = make_tag(fifo_word_pkg::ID_GYRO, slot_snap_q); // RULE18
        {nxt.x_high, nxt.x_low, nxt.y_high, nxt.y_low, nxt.z_high, nxt.z_low} =
          {gyro_snap_q.x, gyro_snap_q.y, gyro_snap_q.z}; // RULE6
      end
      pick.accel: begin
        nxt.tag = make_tag(fifo_word_pkg::ID_ACCEL, slot_snap_q);
        {nxt.x_high, nxt.x_low, nxt.y_high, nxt.y_low, nxt.z_high, nxt.z_low} =
          {accel_snap_q.x, accel_snap_q.y, accel_snap_q.z}; // RULE6
      end
      pick.cfg: begin
        nxt.tag    = make_tag(fifo_word_pkg::ID_CFG, slot_snap_q);
        nxt.x_high = gfilt_q; // RULE15
        nxt.y_low  = afilt_q; // RULE15
        nxt.y_high = {1'b0, startup_q != 20'h00000, 2'h0, hub_rate}; // RULE16
        nxt.z_low  = {gyro_odr, accel_odr}; // RULE16
        nxt.z_high = {gyro_rate, accel_rate}; // RULE16
      end
      pick.ts: begin
        nxt.tag = make_tag(fifo_word_pkg::ID_TS, slot_snap_q);
        {nxt.y_high, nxt.y_low, nxt.x_high, nxt.x_low} = ts_snap_q; // RULE12
        nxt.z_low  = {4'h0, hub_rate}; // RULE12
        nxt.z_high = {gyro_rate, accel_rate}; // RULE12
      end
      pick.temp: begin
        nxt.tag    = make_tag(fifo_word_pkg::ID_TEMP, slot_snap_q);
        nxt.x_low  = temp_snap_q[7:0]; // RULE11
        nxt.x_high = temp_snap_q[15:8]; // RULE11
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_q <= 1'b0;
      out_q       <= '0;
      last_q      <= '0;
    end else begin
      if (load) begin
        out_valid_q <= |job_q;
        out_q       <= nxt;
      end
      if (out_valid_q && word_ready_i) begin
        last_q <= out_q;
      end
    end
  end

  assign word_valid_o = out_valid_q;
  assign word_o       = out_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_slot_adv;
    @(posedge clk_i) disable iff (rst_i) slot_adv |=> slot_q == $past(slot_q) + 2'h1;
  endproperty
  a_slot_adv: assert property (p_slot_adv) else $error("slot counter did not advance"); // RULE4

  property p_slot_hold;
    @(posedge clk_i) disable iff (rst_i) !main_hit |=> $stable(slot_q);
  endproperty
  a_slot_hold: assert property (p_slot_hold) else $error("slot moved without event"); // RULE3

  property p_parity;
    @(posedge clk_i) disable iff (rst_i) word_valid_o |-> !(^word_o.tag);
  endproperty
  a_parity: assert property (p_parity) else $error("tag parity odd"); // RULE19

  property p_temp_zero;
    @(posedge clk_i) disable iff (rst_i)
      word_valid_o && word_o.tag[7:3] == fifo_word_pkg::ID_TEMP |->
      {word_o.y_low, word_o.y_high, word_o.z_low, word_o.z_high} == 32'h0000_0000;
  endproperty
  a_temp_zero: assert property (p_temp_zero) else $error("temperature word not zero"); // RULE11

  property p_cfg_then_ts;
    @(posedge clk_i) disable iff (rst_i)
      word_valid_o && word_ready_i && word_o.tag[7:3] == fifo_word_pkg::ID_CFG |=>
      ##[0:6] word_valid_o && word_o.tag[7:3] == fifo_word_pkg::ID_TS;
  endproperty
  a_cfg_then_ts: assert property (p_cfg_then_ts) else $error("no timestamp after config"); // RULE14

  property p_cfg_enable;
    @(posedge clk_i) disable iff (rst_i)
      $rose(cfg_pend_q) |-> $past(aux_q[fifo_word_pkg::CFG_EN_BIT]);
  endproperty
  a_cfg_enable: assert property (p_cfg_enable) else $error("config change while off"); // RULE10

  property p_temp_off;
    @(posedge clk_i) disable iff (rst_i)
      aux_q[fifo_word_pkg::TEMP_LSB +: 2] == 2'h0 && !job_q.temp |=> !job_q.temp;
  endproperty
  a_temp_off: assert property (p_temp_off) else $error("temperature batched while off"); // RULE8

  property p_startup;
    @(posedge clk_i) disable iff (rst_i)
      gyro_on && !gyro_on_q |=> startup_q == STARTUP_CYCLES;
  endproperty
  a_startup: assert property (p_startup) else $error("start-up flag not raised"); // RULE17

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

endmodule

`default_nettype wire

/* verification/word_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Word consumer that stalls at random when asked to be slow
// ----------------------------------------------------------------------
module word_host_model (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 slow_i,
  input  wire logic                 word_valid_i,
  input  wire fifo_word_pkg::word_t word_i,
  output logic                      word_ready_o
);
  fifo_word_pkg::word_t seen[$];
  logic [31:0]          rnd_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      word_ready_o <= 1'b0;
      rnd_q        <= 32'h0000_1234;
    end else begin
      if (word_valid_i && word_ready_o) begin
        seen.push_back(word_i);
      end
      rnd_q        <= {rnd_q[30:0], rnd_q[31] ^ rnd_q[21] ^ rnd_q[1] ^ rnd_q[0]};
      word_ready_o <= slow_i ? rnd_q[0] : 1'b1;
    end
  end
endmodule
`default_nettype wire

/* verification/fifo_batch_word_formatter_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fifo_batch_word_formatter_test;
  logic clk_i, rst_i, we, cyc, stb, slow, a_evt, g_evt, ack, valid, ready;
  logic [31:0] adr, wdat, rdat, ts, q, seed, lr, r;
  logic [15:0] temp;
  logic [1:0]  slot, sl;
  logic [7:0]  gf, af;
  logic [3:0]  a_rate, g_rate;
  fifo_word_pkg::axis_t ad, gd;
  fifo_word_pkg::word_t wo, last, w;
  fifo_word_pkg::word_t exp_q[$];
  int errors, checks;
  bit cfg_pend, temp_on, ts_on;

  fifo_batch_word_formatter #(.STARTUP_CYCLES(20'h00014)) fifo_batch_word_formatter_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .accel_evt_i(a_evt), .gyro_evt_i(g_evt), .accel_data_i(ad), .gyro_data_i(gd),
    .temp_data_i(temp), .timestamp_i(ts), .word_valid_o(valid), .word_o(wo),
    .word_ready_i(ready), .slot_counter_o(sl));
  word_host_model word_host_model_inst (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .word_valid_i(valid), .word_i(wo), .word_ready_o(ready));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic fifo_word_pkg::word_t mk(logic [4:0] id, logic [47:0] d);
    logic [7:0] t;
    t = {id, slot, ^{id, slot}};
    return {t, d[39:32], d[47:40], d[23:16], d[31:24], d[7:0], d[15:8]};
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] want);
    checks++;
    if (got !== want) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  task automatic wb(input logic w_en, input logic [6:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w_en; adr <= {23'h0, idx, 2'b00}; wdat <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) errors++;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic fire(input bit acc, input bit gyr);
    int n;
    bit adv;
    fifo_word_pkg::axis_t a_v, g_v;
    logic [15:0] t_v;
    logic [31:0] s_v;
    @(posedge clk_i);
    a_v = 48'({rnd(), rnd()});
    g_v = 48'({rnd(), rnd()});
    r = rnd();
    t_v = r[15:0];
    s_v = rnd();
    ad <= a_v; gd <= g_v; temp <= t_v; ts <= s_v;
    a_evt <= acc; g_evt <= gyr;
    adv = (a_rate >= g_rate) ? acc : gyr;
    if (adv) slot++;
    if (gyr) exp_q.push_back(mk(fifo_word_pkg::ID_GYRO, g_v));
    if (acc) exp_q.push_back(mk(fifo_word_pkg::ID_ACCEL, a_v));
    if (cfg_pend) exp_q.push_back(mk(fifo_word_pkg::ID_CFG,
      {gf, 8'h00, 8'h00, af & 8'hdf, g_rate, a_rate, lr[7:0]}));
    if (cfg_pend || (adv && ts_on)) exp_q.push_back(mk(fifo_word_pkg::ID_TS,
      {s_v[15:0], s_v[31:16], g_rate, a_rate, 8'h00}));
    if (adv && temp_on) exp_q.push_back(mk(fifo_word_pkg::ID_TEMP, {t_v, 32'h0}));
    cfg_pend = 0;
    @(posedge clk_i);
    a_evt <= 1'b0; g_evt <= 1'b0;
    n = 0;
    while (word_host_model_inst.seen.size() < exp_q.size() && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    repeat (3) @(posedge clk_i);
    check(word_host_model_inst.seen.size(), exp_q.size());
    check(sl, slot);
    while (exp_q.size() > 0 && word_host_model_inst.seen.size() > 0) begin
      w = word_host_model_inst.seen.pop_front();
      last = exp_q.pop_front();
      check(w, last);
    end
    exp_q.delete();
    word_host_model_inst.seen.delete();
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #5_000_000;
    errors++;
    print_verdict();
  end

  initial begin
    seed = 32'hd60c; errors = 0; checks = 0; slot = 2'h0; cfg_pend = 0;
    rst_i = 1'b1; we = 0; cyc = 0; stb = 0; slow = 0; a_evt = 0; g_evt = 0;
    adr = 0; wdat = 0; ad = 0; gd = 0; temp = 0; ts = 0; temp_on = 0; ts_on = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, 7'(i), 32'h0);
      check(q, 32'h0);
    end
    wb(1'b0, 7'h40, 32'h0);
    check(q, 32'h0);
    lr = 32'h66;
    wb(1'b1, fifo_word_pkg::IDX_ODR, lr);
    a_rate = 4'h4; g_rate = 4'h2;
    wb(1'b1, fifo_word_pkg::IDX_BATCH, {24'h0, g_rate, a_rate});
    wb(1'b0, fifo_word_pkg::IDX_BATCH, 32'h0);
    check(q, 32'h24);
    wb(1'b1, fifo_word_pkg::IDX_GFILT, 32'h5a);
    fire(1, 0);
    fire(0, 1);
    $display("test disabled auxiliaries done");
    temp_on = 1; ts_on = 1;
    wb(1'b1, fifo_word_pkg::IDX_AUX, 32'h15);
    for (int i = 0; i < 14; i++) begin
      r = rnd();
      slow = r[0];
      fire(r[1], r[2]);
      if (i == 7) begin
        a_rate = 4'h3; g_rate = 4'h5;
        wb(1'b1, fifo_word_pkg::IDX_BATCH, 32'h53);
      end
    end
    $display("test random batching done");
    wb(1'b1, fifo_word_pkg::IDX_AUX, 32'h25);
    ts_on = 0;
    r = rnd();
    gf = r[7:0] | 8'h01;
    af = r[15:8];
    wb(1'b1, fifo_word_pkg::IDX_GFILT, {24'h0, gf});
    wb(1'b1, fifo_word_pkg::IDX_AFILT, {24'h0, af});
    cfg_pend = 1;
    fire(1, 0);
    gf = ~gf;
    wb(1'b1, fifo_word_pkg::IDX_GFILT, {24'h0, gf});
    cfg_pend = 1;
    fire(0, 1);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, 7'(fifo_word_pkg::IDX_TAG + i), 32'h0);
      check(q, {24'h0, 8'(last >> (48 - 8 * i))});
    end
    $display("test configuration change done");
    print_verdict();
  end
endmodule
`default_nettype wire
